// file: hw/atr_prescaler.sv
// clock prescaler: divides the source enable down to the timer tick
// assumes: src_en is a one-cycle pulse per source clock period
`timescale 1ns/1ps
`default_nettype none
`include "atr_cfg.svh"
module atr_prescaler #(
  parameter int PS_W = `ATR_PS_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic src_en,
  input wire atr_pkg::atr_prescale_t sel,
  output logic tick
);
  import atr_pkg::*;

  // refuse a divider too short for the longest ratio
  if (PS_W < `ATR_PS_W)
  begin : g_width_chk
    $error("prescaler too narrow for divide by 1024");
  end

  logic [PS_W-1:0] div_q;
  logic [PS_W-1:0] div_d;
  logic [PS_W-1:0] mask;

  // ----------------------------------------
  // divider chain
  // ----------------------------------------
  always_comb
  begin
    div_d = src_en ? div_q + 1'b1 : div_q;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      div_q <= '0;
    else
      div_q <= div_d;
  end

  // ----------------------------------------
  // tap select
  // ----------------------------------------
  // select division tap
  always_comb
  begin
    mask = '0;
    case (sel)
      PS_DIV8: mask = PS_W'(`ATR_PS_MASK_8);
      PS_DIV32: mask = PS_W'(`ATR_PS_MASK_32);
      PS_DIV64: mask = PS_W'(`ATR_PS_MASK_64);
      PS_DIV128: mask = PS_W'(`ATR_PS_MASK_128);
      PS_DIV256: mask = PS_W'(`ATR_PS_MASK_256);
      PS_DIV1024: mask = PS_W'(`ATR_PS_MASK_1024);
      default: mask = '0;
    endcase
    tick = src_en && (sel != PS_STOP) && ((div_q & mask) == mask);
  end
endmodule : atr_prescaler
`default_nettype wire

// file: hw/atr_timer2.sv
// 8-bit timer/counter with two compare channels and its registers
// assumes: one clock; oscillator pin sampled as a plain input
// Summary of operation
// - force bit A forces match on output A
// - forced match sets no flag, no clear
// - force bit B behaves like A
// - force bits read zero, non-PWM only
// - reserved bits always read zero; CTRL1 bits 3:2 are stored and read back as written
// - prescale select picks stop or divide ratio
// - counter read/write; write blocks next match
// - compare values continuously checked against counter
// - enable bits gate flags to interrupt requests
// - compare flags set on match, cleared two ways
// - overflow flag; in phase PWM set at bottom turn, in fast PWM at top
// - external clock buffer versus crystal oscillator
// - async select picks io or oscillator clock
// - switching clock source needs register rewrite
// - async count write holds busy until transfer
// - mode bits select normal, ctc, fast, phase
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "atr_cfg.svh"
module atr_timer2 (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic global_irq_en,
  input wire logic [2:0] vec_ack,
  input wire logic timer_osc_pin,
  output logic wave_out_a,
  output logic wave_out_a_oe,
  output logic wave_out_b,
  output logic wave_out_b_oe,
  output logic osc_amp_en,
  output logic ext_clk_buf_en,
  output logic irq_overflow,
  output logic irq_match_a,
  output logic irq_match_b
);
  import atr_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] c1_q, c1_d, c1l_q, c1l_d;
  logic [3:0] c2_q, c2_d, c2l_q, c2l_d;
  logic [7:0] ma_q, ma_d, mal_q, mal_d;
  logic [7:0] mb_q, mb_d, mbl_q, mbl_d;
  logic [7:0] cnt_q, cnt_d, pend_q, pend_d;
  logic [4:0] busy_q, busy_d;
  logic ext_q, ext_d, asel_q, asel_d;
  logic [2:0] ien_q, ien_d, flg_q, flg_d;
  logic up_q, up_d, blk_q, blk_d;
  logic wa_q, wa_d, wb_q, wb_d;
  logic [7:0] rdata_q, rdata_d;
  logic osc_s1_q, osc_s2_q, osc_s3_q;

  logic src_en, tick;
  logic w_c1, w_c2, w_ma, w_mb, w_cnt, w_ien, w_flg, w_as;
  logic [7:0] top;
  atr_wave_kind_t kind;
  logic top_a, non_pwm, at_top, at_bot, hit_a, hit_b, frc_a, frc_b;
  logic [2:0] set_f, clr_f;

  // ----------------------------------------
  // oscillator pin and prescaler
  // ----------------------------------------
  // two-stage sync before edge use
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end
    else
    begin
      osc_s1_q <= timer_osc_pin;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  assign src_en = asel_q ? (osc_s2_q & ~osc_s3_q) : 1'b1;

  atr_prescaler #(
    .PS_W(`ATR_PS_W)
  ) u_ps (
    .clk(clk),
    .rstn(rstn),
    .src_en(src_en),
    .sel(atr_prescale_t'(c2l_q[`ATR_C2_PS_HI:`ATR_C2_PS_LO])),
    .tick(tick)
  );

  // buffer only when async, crystal only without ext
  assign ext_clk_buf_en = ext_q & asel_q;
  assign osc_amp_en = ~ext_q;

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  // three mode bits to kind and top
  always_comb
  begin
    top_a = c2l_q[`ATR_C2_WMU];
    case (c1l_q[`ATR_C1_WML_HI:`ATR_C1_WML_LO])
      2'b01: kind = WK_PHASE;
      2'b10: kind = WK_CTC;
      2'b11: kind = WK_FAST;
      default: kind = WK_NORMAL;
    endcase
    // reserved codes fall back to normal (top 0xff) or ctc (top match A)
    if (kind == WK_NORMAL || kind == WK_CTC)
      top_a = (kind == WK_CTC);
    top = top_a ? mal_q : `ATR_CNT_MAX;
    non_pwm = (kind == WK_NORMAL) || (kind == WK_CTC);
    at_top = (cnt_q == top);
    at_bot = (cnt_q == `ATR_CNT_BOTTOM);
  end

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  always_comb
  begin
    w_c1 = wr && (addr == `ATR_OFS_CTRL1);
    w_c2 = wr && (addr == `ATR_OFS_CTRL2);
    w_ma = wr && (addr == `ATR_OFS_MATCH_A);
    w_mb = wr && (addr == `ATR_OFS_MATCH_B);
    w_cnt = wr && (addr == `ATR_OFS_COUNT);
    w_ien = wr && (addr == `ATR_OFS_IRQ_EN);
    w_flg = wr && (addr == `ATR_OFS_FLAGS);
    w_as = wr && (addr == `ATR_OFS_ASYNC);
    frc_a = w_c2 && wdata[`ATR_C2_FORCE_A] && non_pwm;
    frc_b = w_c2 && wdata[`ATR_C2_FORCE_B] && non_pwm;
    // match blocked after a count write
    hit_a = tick && !blk_q && (cnt_q == mal_q);
    hit_b = tick && !blk_q && (cnt_q == mbl_q);
  end

  // ----------------------------------------
  // waveform output step
  // ----------------------------------------
  function automatic logic wave_step(input logic cur, input atr_out_mode_t m,
                                     input atr_wave_kind_t k, input logic hit,
                                     input logic frc, input logic wrap,
                                     input logic up, input logic tog_ok);
    logic v;
    v = cur;
    case (k)
      WK_FAST:
      begin
        if (m == OM_CLEAR)
          v = hit ? 1'b0 : (wrap ? 1'b1 : cur);
        else if (m == OM_SET)
          v = hit ? 1'b1 : (wrap ? 1'b0 : cur);
        else if (m == OM_TOGGLE && tog_ok && hit)
          v = ~cur;
      end
      WK_PHASE:
      begin
        if (hit && m == OM_CLEAR)
          v = ~up;
        else if (hit && m == OM_SET)
          v = up;
        else if (hit && m == OM_TOGGLE && tog_ok)
          v = ~cur;
      end
      default:
      begin
        if (hit || frc)
        begin
          case (m)
            OM_TOGGLE: v = ~cur;
            OM_CLEAR: v = 1'b0;
            OM_SET: v = 1'b1;
            default: v = cur;
          endcase
        end
      end
    endcase
    return v;
  endfunction : wave_step

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    c1_d = c1_q;
    c2_d = c2_q;
    ma_d = ma_q;
    mb_d = mb_q;
    c1l_d = c1l_q;
    c2l_d = c2l_q;
    mal_d = mal_q;
    mbl_d = mbl_q;
    cnt_d = cnt_q;
    pend_d = pend_q;
    busy_d = busy_q;
    ext_d = ext_q;
    asel_d = asel_q;
    ien_d = ien_q;
    up_d = up_q;
    blk_d = blk_q;
    set_f = '0;
    clr_f = '0;

    // counting sequence
    if (tick)
    begin
      blk_d = 1'b0;
      case (kind)
        WK_PHASE:
        begin
          if (up_q && at_top)
          begin
            up_d = 1'b0;
            cnt_d = cnt_q - 1'b1;
          end
          else if (!up_q && at_bot)
          begin
            up_d = 1'b1;
            cnt_d = cnt_q + 1'b1;
          end
          else
            cnt_d = up_q ? cnt_q + 1'b1 : cnt_q - 1'b1;
        end
        WK_NORMAL:
          cnt_d = cnt_q + 1'b1;
        default:
        begin
          up_d = 1'b1;
          cnt_d = at_top ? `ATR_CNT_BOTTOM : cnt_q + 1'b1;
        end
      endcase
      // overflow at max, top, or bottom turn
      case (kind)
        WK_PHASE: set_f[`ATR_IRQ_OV] = !up_q && at_bot;
        WK_FAST: set_f[`ATR_IRQ_OV] = at_top;
        default: set_f[`ATR_IRQ_OV] = (cnt_q == `ATR_CNT_MAX);
      endcase
    end
    // forced strobes never reach the flags
    set_f[`ATR_IRQ_MA] = hit_a;
    set_f[`ATR_IRQ_MB] = hit_b;

    // register writes; async ones wait in the shadow
    if (w_c1)
      c1_d = wdata;
    if (w_c2)
      c2_d = wdata[`ATR_C2_WMU:`ATR_C2_PS_LO];
    if (w_ma)
      ma_d = wdata;
    if (w_mb)
      mb_d = wdata;
    if (w_ien)
      ien_d = wdata[`ATR_IRQ_MB:`ATR_IRQ_OV];
    // order of ext and async writes left to software
    if (w_as)
    begin
      ext_d = wdata[`ATR_AS_EXT];
      asel_d = wdata[`ATR_AS_SEL];
    end
    if (w_flg)
      clr_f = wdata[`ATR_IRQ_MB:`ATR_IRQ_OV];
    clr_f = clr_f | vec_ack;

    if (!asel_q)
    begin
      if (w_cnt)
      begin
        cnt_d = wdata;
        blk_d = 1'b1;
      end
      c1l_d = c1_d;
      c2l_d = c2_d;
      mal_d = ma_d;
      mbl_d = mb_d;
      busy_d = '0;
    end
    else
    begin
      // transfer on the next oscillator edge
      if (src_en)
      begin
        if (busy_q[`ATR_BUSY_CNT])
        begin
          cnt_d = pend_q;
          blk_d = 1'b1;
        end
        c1l_d = c1_q;
        c2l_d = c2_q;
        mal_d = ma_q;
        mbl_d = mb_q;
        busy_d = '0;
      end
      if (w_cnt)
        pend_d = wdata;
      busy_d = busy_d | {w_cnt, w_ma, w_mb, w_c1, w_c2};
    end
  end

  assign flg_d = (flg_q & ~clr_f) | set_f;

  always_comb
  begin
    wa_d = wave_step(wa_q, atr_out_mode_t'(c1l_q[`ATR_C1_OMA_HI:`ATR_C1_OMA_LO]), kind,
                     hit_a, frc_a, tick && at_top, up_q, top_a);
    wb_d = wave_step(wb_q, atr_out_mode_t'(c1l_q[`ATR_C1_OMB_HI:`ATR_C1_OMB_LO]), kind,
                     hit_b, frc_b, tick && at_top, up_q, 1'b0);
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // reserved and force bits read zero except CTRL1 bits 3:2, which read back as written
  always_comb
  begin
    rdata_d = '0;
    if (rd)
    begin
      case (addr)
        `ATR_OFS_CTRL1: rdata_d = c1_q;
        `ATR_OFS_CTRL2: rdata_d = {4'h0, c2_q};
        `ATR_OFS_MATCH_A: rdata_d = ma_q;
        `ATR_OFS_MATCH_B: rdata_d = mb_q;
        `ATR_OFS_COUNT: rdata_d = cnt_q;
        `ATR_OFS_IRQ_EN: rdata_d = {5'h00, ien_q};
        `ATR_OFS_FLAGS: rdata_d = {5'h00, flg_q};
        `ATR_OFS_ASYNC: rdata_d = {1'b0, ext_q, asel_q, busy_q};
        default: rdata_d = '0;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // no scrubbing on a source switch
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      c1_q <= `ATR_RST_8;
      c1l_q <= `ATR_RST_8;
      c2_q <= '0;
      c2l_q <= '0;
      ma_q <= `ATR_RST_8;
      mal_q <= `ATR_RST_8;
      mb_q <= `ATR_RST_8;
      mbl_q <= `ATR_RST_8;
      cnt_q <= `ATR_RST_8;
      pend_q <= `ATR_RST_8;
      busy_q <= '0;
      ext_q <= 1'b0;
      asel_q <= 1'b0;
      ien_q <= '0;
      flg_q <= '0;
      up_q <= 1'b1;
      blk_q <= 1'b0;
      wa_q <= 1'b0;
      wb_q <= 1'b0;
      rdata_q <= `ATR_RST_8;
    end
    else
    begin
      c1_q <= c1_d;
      c1l_q <= c1l_d;
      c2_q <= c2_d;
      c2l_q <= c2l_d;
      ma_q <= ma_d;
      mal_q <= mal_d;
      mb_q <= mb_d;
      mbl_q <= mbl_d;
      cnt_q <= cnt_d;
      pend_q <= pend_d;
      busy_q <= busy_d;
      ext_q <= ext_d;
      asel_q <= asel_d;
      ien_q <= ien_d;
      flg_q <= flg_d;
      up_q <= up_d;
      blk_q <= blk_d;
      wa_q <= wa_d;
      wb_q <= wb_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rdata = rdata_q;
  assign wave_out_a = wa_q;
  assign wave_out_b = wb_q;
  assign wave_out_a_oe = (c1l_q[`ATR_C1_OMA_HI:`ATR_C1_OMA_LO] != OM_OFF);
  assign wave_out_b_oe = (c1l_q[`ATR_C1_OMB_HI:`ATR_C1_OMB_LO] != OM_OFF);
  assign irq_overflow = global_irq_en & ien_q[`ATR_IRQ_OV] & flg_q[`ATR_IRQ_OV];
  assign irq_match_a = global_irq_en & ien_q[`ATR_IRQ_MA] & flg_q[`ATR_IRQ_MA];
  assign irq_match_b = global_irq_en & ien_q[`ATR_IRQ_MB] & flg_q[`ATR_IRQ_MB];
endmodule : atr_timer2
`default_nettype wire

// file: pkg/atr_cfg.svh
// offsets, field positions and reset values of the timer register block
// assumes: included by bare name from package and design files
`ifndef ATR_CFG_SVH
`define ATR_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ATR_OFS_IRQ_EN 8'h70
`define ATR_OFS_FLAGS 8'h37
`define ATR_OFS_CTRL1 8'hb0
`define ATR_OFS_CTRL2 8'hb1
`define ATR_OFS_COUNT 8'hb2
`define ATR_OFS_MATCH_A 8'hb3
`define ATR_OFS_MATCH_B 8'hb4
`define ATR_OFS_ASYNC 8'hb6

// ----------------------------------------
// field positions
// ----------------------------------------
`define ATR_C2_FORCE_A 7
`define ATR_C2_FORCE_B 6
`define ATR_C2_WMU 3
`define ATR_C2_PS_HI 2
`define ATR_C2_PS_LO 0
`define ATR_C1_OMA_HI 7
`define ATR_C1_OMA_LO 6
`define ATR_C1_OMB_HI 5
`define ATR_C1_OMB_LO 4
`define ATR_C1_WML_HI 1
`define ATR_C1_WML_LO 0
`define ATR_AS_EXT 6
`define ATR_AS_SEL 5
`define ATR_BUSY_CNT 4
`define ATR_BUSY_A 3
`define ATR_BUSY_B 2
`define ATR_BUSY_C1 1
`define ATR_BUSY_C2 0
`define ATR_IRQ_MB 2
`define ATR_IRQ_MA 1
`define ATR_IRQ_OV 0

// ----------------------------------------
// values
// ----------------------------------------
`define ATR_RST_8 8'h00
`define ATR_CNT_MAX 8'hff
`define ATR_CNT_BOTTOM 8'h00
`define ATR_PS_MASK_8 10'h007
`define ATR_PS_MASK_32 10'h01f
`define ATR_PS_MASK_64 10'h03f
`define ATR_PS_MASK_128 10'h07f
`define ATR_PS_MASK_256 10'h0ff
`define ATR_PS_MASK_1024 10'h3ff
`define ATR_PS_W 10

`endif

// file: pkg/atr_pkg.sv
// types shared by the timer register block
// assumes: atr_cfg.svh on the include path
`default_nettype none
package atr_pkg;
  `include "atr_cfg.svh"

  typedef enum logic [1:0] {OM_OFF, OM_TOGGLE, OM_CLEAR, OM_SET} atr_out_mode_t;

  typedef enum logic [1:0] {WK_NORMAL, WK_CTC, WK_FAST, WK_PHASE} atr_wave_kind_t;

  typedef enum logic [2:0] {PS_STOP, PS_DIV1, PS_DIV8, PS_DIV32, PS_DIV64, PS_DIV128,
                            PS_DIV256, PS_DIV1024} atr_prescale_t;
endpackage : atr_pkg
`default_nettype wire

// file: testbench/atr_osc_model.sv
// oscillator at the timer oscillator pin
// assumes: run reflects the bench and the pin-side enables
`timescale 1ns/1ps
`default_nettype none
module atr_osc_model #(
  parameter int HALF_NS = 400
) (
  input wire logic run,
  output logic pin
);
  // ----------------
  // oscillation
  // ----------------
  // stopped pin holds, so no stray source edges
  // runs only when enabled
  initial
  begin
    pin = 1'b0;
    forever
    begin
      #(HALF_NS);
      if (run)
        pin = ~pin;
    end
  end
endmodule : atr_osc_model
`default_nettype wire

// file: testbench/atr_timer2_asserts.sv
// port checker for the timer register block
// assumes: bound to atr_timer2, one clock, reset rstn
`timescale 1ns/1ps
`default_nettype none
module atr_timer2_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic global_irq_en,
  input wire logic [2:0] vec_ack,
  input wire logic timer_osc_pin,
  input wire logic wave_out_a,
  input wire logic wave_out_a_oe,
  input wire logic wave_out_b,
  input wire logic wave_out_b_oe,
  input wire logic osc_amp_en,
  input wire logic ext_clk_buf_en,
  input wire logic irq_overflow,
  input wire logic irq_match_a,
  input wire logic irq_match_b
);
  import atr_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ----------------
  // assertions
  // ----------------
  // force bits read zero
  force_rd_zero_a: assert property (rd && addr == 8'hb1 |=> rdata[7:6] == 2'h0)
    else $error("force bits read back set");
  ctrl_resv_a: assert property (rd && addr == 8'hb1 |=> rdata[5:4] == 2'h0)
    else $error("reserved control bits set");
  stat_resv_a: assert property (rd && addr == 8'hb6 |=> !rdata[7])
    else $error("reserved status bit set");
  en_resv_a: assert property (rd && addr == 8'h70 |=> rdata[7:3] == 5'h00)
    else $error("unused enable bits set");
  // no decode, reads zero
  unmapped_rd_a: assert property (rd && addr == 8'h00 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  irq_global_a: assert property (!global_irq_en |-> !(irq_overflow || irq_match_a || irq_match_b))
    else $error("request without global enable");
  buf_amp_a: assert property (ext_clk_buf_en |-> !osc_amp_en)
    else $error("crystal runs with buffer on");
  amp_src_a: assert property ($changed(osc_amp_en) || $changed(ext_clk_buf_en)
    |-> $past(wr) && $past(addr) == 8'hb6)
    else $error("clock pin control moved alone");
  oe_src_a: assert property ($changed(wave_out_a_oe) || $changed(wave_out_b_oe)
    |-> $past(wr) && $past(addr) == 8'hb0)
    else $error("output enable moved alone");
  force_cv: cover property (wr && addr == 8'hb1 && wdata[7]);
  async_cv: cover property ($rose(ext_clk_buf_en));
  irq_cv: cover property ($rose(irq_match_a));
endmodule : atr_timer2_asserts
bind atr_timer2 atr_timer2_asserts chk_u (.clk(clk), .rstn(rstn), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .global_irq_en(global_irq_en),
  .vec_ack(vec_ack), .timer_osc_pin(timer_osc_pin), .wave_out_a(wave_out_a),
  .wave_out_a_oe(wave_out_a_oe), .wave_out_b(wave_out_b), .wave_out_b_oe(wave_out_b_oe),
  .osc_amp_en(osc_amp_en), .ext_clk_buf_en(ext_clk_buf_en), .irq_overflow(irq_overflow),
  .irq_match_a(irq_match_a), .irq_match_b(irq_match_b));
`default_nettype wire

// file: testbench/atr_timer2_tb.sv
// self-checking bench for the timer register block
// assumes: atr_osc_model on the pin, checker bound
`timescale 1ns/1ps
`default_nettype none
module atr_timer2_tb;
  import atr_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic global_irq_en = 1'b0;
  logic [2:0] vec_ack = 3'h0;
  logic osc_on = 1'b0;
  logic pin, wa, wb, woa, wob, amp, xbuf, iov, ima, imb;
  logic [7:0] rdata;
  logic [7:0] v, v0;
  int error_cnt = 0;
  int n_compared = 0;
  int div[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  always #12.5 clk = ~clk;
  atr_osc_model osc_u (.run(osc_on && (amp || xbuf)), .pin(pin));
  atr_timer2 dut_u (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .global_irq_en(global_irq_en), .vec_ack(vec_ack),
    .timer_osc_pin(pin), .wave_out_a(wa), .wave_out_a_oe(woa), .wave_out_b(wb),
    .wave_out_b_oe(wob), .osc_amp_en(amp), .ext_clk_buf_en(xbuf),
    .irq_overflow(iov), .irq_match_a(ima), .irq_match_b(imb));
  // ----------------
  // helpers
  // ----------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // gap cycle between strobes keeps one assignment per time step
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] r);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 r = rdata;
  endtask : rd_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    rd_reg(a, r);
    check(r, e);
  endtask : rd_chk
  task automatic pulse_ack(input logic [2:0] m);
    @(posedge clk);
    vec_ack <= m;
    @(posedge clk);
    vec_ack <= 3'h0;
    #1;
  endtask : pulse_ack
  task automatic wait_busy(input int b);
    for (int i = 0; i < 100; i++)
    begin
      rd_reg(8'hb6, v);
      if (v[b] === 1'b0)
        break;
    end
    check({7'h0, v[b]}, 8'h00);
  endtask : wait_busy
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  // ----------------
  // scenarios
  // ----------------
  task automatic t_regs();
    logic [7:0] ofs[5] = '{8'h70, 8'hb1, 8'hb6, 8'h37, 8'hb2};
    foreach (ofs[i])
      rd_chk(ofs[i], 8'h00);
    wr_reg(8'h00, 8'hff);
    rd_chk(8'h00, 8'h00);
    wr_reg(8'h70, 8'hff);
    rd_chk(8'h70, 8'h07);
    wr_reg(8'hb1, 8'hff);
    rd_chk(8'hb1, 8'h0f);
    wr_reg(8'hb1, 8'h00);
    wr_reg(8'hb6, 8'h9f);
    rd_chk(8'hb6, 8'h00);
    wr_reg(8'hb6, 8'h40);
    check({6'h0, amp, xbuf}, 8'h00);
    wr_reg(8'hb6, 8'h60);
    check({6'h0, amp, xbuf}, 8'h01);
    wr_reg(8'hb6, 8'h00);
    check({6'h0, amp, xbuf}, 8'h02);
  endtask : t_regs
  task automatic t_prescale();
    for (int s = 1; s < 8; s++)
    begin
      wr_reg(8'hb2, 8'h00);
      wr_reg(8'hb1, 8'(s));
      repeat (4 * div[s] - 2) @(posedge clk);
      wr_reg(8'hb1, 8'h00);
      rd_reg(8'hb2, v);
      check({7'h0, v >= 8'h03 && v <= 8'h05}, 8'h01);
    end
    repeat (40) @(posedge clk);
    rd_chk(8'hb2, v);
  endtask : t_prescale
  task automatic t_match();
    wr_reg(8'hb3, 8'h10);
    wr_reg(8'hb4, 8'h20);
    wr_reg(8'h37, 8'h07);
    wr_reg(8'hb2, 8'h00);
    wr_reg(8'hb1, 8'h01);
    repeat (40) @(posedge clk);
    wr_reg(8'hb1, 8'h00);
    rd_chk(8'h37, 8'h06);
    check({5'h0, imb, ima, iov}, 8'h06);
    @(posedge clk);
    global_irq_en <= 1'b0;
    #1 check({5'h0, imb, ima, iov}, 8'h00);
    @(posedge clk);
    global_irq_en <= 1'b1;
    pulse_ack(3'b010);
    rd_chk(8'h37, 8'h04);
    wr_reg(8'h37, 8'h00);
    rd_chk(8'h37, 8'h04);
    wr_reg(8'h37, 8'h04);
    rd_chk(8'h37, 8'h00);
    wr_reg(8'hb2, 8'hfc);
    wr_reg(8'hb1, 8'h01);
    repeat (10) @(posedge clk);
    wr_reg(8'hb1, 8'h00);
    rd_chk(8'h37, 8'h01);
    check({7'h0, iov}, 8'h01);
    pulse_ack(3'b001);
    rd_chk(8'h37, 8'h00);
    // count written onto the match value while running
    wr_reg(8'hb2, 8'h80);
    wr_reg(8'hb1, 8'h01);
    wr_reg(8'hb2, 8'h10);
    wr_reg(8'hb1, 8'h00);
    rd_chk(8'h37, 8'h00);
  endtask : t_match
  task automatic t_force();
    logic a0, b0;
    wr_reg(8'hb0, 8'h52);
    check({6'h0, woa, wob}, 8'h03);
    wr_reg(8'hb2, 8'h33);
    a0 = wa;
    b0 = wb;
    wr_reg(8'hb1, 8'h80);
    check({6'h0, wa, wb}, {6'h0, ~a0, b0});
    wr_reg(8'hb1, 8'h40);
    check({6'h0, wa, wb}, {6'h0, ~a0, ~b0});
    rd_chk(8'h37, 8'h00);
    rd_chk(8'hb2, 8'h33);
    rd_chk(8'hb1, 8'h00);
    wr_reg(8'hb0, 8'h53);
    a0 = wa;
    b0 = wb;
    wr_reg(8'hb1, 8'hc0);
    check({6'h0, wa, wb}, {6'h0, a0, b0});
    wr_reg(8'hb0, 8'h00);
  endtask : t_force
  task automatic t_modes();
    // clear-on-match kind wraps after match A
    wr_reg(8'hb3, 8'h04);
    wr_reg(8'hb0, 8'h02);
    wr_reg(8'hb2, 8'h00);
    wr_reg(8'h37, 8'h07);
    wr_reg(8'hb1, 8'h01);
    repeat (10) @(posedge clk);
    wr_reg(8'hb1, 8'h00);
    rd_chk(8'hb2, 8'h02);
    rd_chk(8'h37, 8'h02);
    // phase kind with top at match A
    wr_reg(8'hb0, 8'h01);
    wr_reg(8'hb2, 8'h00);
    wr_reg(8'h37, 8'h07);
    wr_reg(8'hb1, 8'h09);
    repeat (8) @(posedge clk);
    wr_reg(8'hb1, 8'h00);
    rd_chk(8'hb2, 8'h02);
    rd_chk(8'h37, 8'h03);
    wr_reg(8'hb0, 8'h00);
  endtask : t_modes
  task automatic t_async();
    wr_reg(8'hb6, 8'h40);
    wr_reg(8'hb6, 8'h60);
    wr_reg(8'hb2, 8'h05);
    rd_chk(8'hb6, 8'h70);
    osc_on <= 1'b1;
    wait_busy(4);
    rd_chk(8'hb2, 8'h05);
    wr_reg(8'hb1, 8'h01);
    wait_busy(0);
    rd_reg(8'hb2, v0);
    repeat (192) @(posedge clk);
    rd_reg(8'hb2, v);
    v = v - v0;
    check({7'h0, v >= 8'h05 && v <= 8'h07}, 8'h01);
    wr_reg(8'hb1, 8'h00);
    wait_busy(0);
    osc_on <= 1'b0;
    wr_reg(8'hb6, 8'h40);
    wr_reg(8'hb6, 8'h00);
  endtask : t_async
  // ----------------
  // sequence
  // ----------------
  initial
  begin
    #1500000;
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    @(posedge clk);
    global_irq_en <= 1'b1;
    t_prescale();
    t_match();
    t_force();
    t_modes();
    t_async();
    wrap_up();
  end
endmodule : atr_timer2_tb
`default_nettype wire
